// file: rtl/output_port_retry_recovery.sv
// Output-port retry recovery state machine
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - After reset sit in recovery disabled until the output port is enabled.
// - The output port is enabled only after training completes and software allows.
// - Port enabled moves recovery disabled to wait for retry.
// - Port disabled in wait for retry returns to recovery disabled.
// - Only an error-free retry symbol may start retry recovery.
// - A valid retry symbol in wait for retry enters stop output.
// - Stop output clears ready, sets retry halted, stops new packet launches.
// - Finished stop procedure advances to recover.
// - Recover resends from the returned tag onward, including later packets.
// - Recover rewinds tag scoreboard, clears halted and sets ready in the same cycle.
// - Not-accepted or output error in recover hands over to error recovery.
// - Once resend began and recovery is done, return to wait for retry.
module output_port_retry_recovery
    import retry_recovery_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic training_done,
    input wire logic sw_enable,
    input wire logic [TAG_W-1:0] symbol_tag,
    input wire logic symbol_valid,
    input wire logic symbol_retry,
    input wire logic symbol_not_accepted,
    input wire logic symbol_crc_error,
    input wire logic output_error,
    input wire logic packet_sent,
    input wire logic link_clk,
    output logic port_ready,
    output logic retry_halted,
    output logic launch_enable,
    output logic resend_start,
    output logic [TAG_W-1:0] resend_tag,
    output logic to_error_recovery,
    output logic [TAG_W-1:0] next_tag,
    output logic [1:0] state_out
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [TAG_W+7:0] sync1_q;
    logic [TAG_W+7:0] sync2_q;
    logic [TAG_W+7:0] sync1_d;
    logic link_clk_prev_q;
    logic link_clk_prev_d;
    logic link_edge;
    symbol_t sym;

    always_comb begin
        sync1_d = {training_done, sw_enable, symbol_tag, symbol_valid,
                   symbol_retry, symbol_not_accepted, symbol_crc_error,
                   output_error, link_clk};
        link_clk_prev_d = sync2_q[0];
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            link_clk_prev_q <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync1_q;
            link_clk_prev_q <= link_clk_prev_d;
        end
    end

    logic s_training_done;
    logic s_sw_enable;
    logic s_output_error;
    logic port_enabled;

    always_comb begin
        s_training_done = sync2_q[TAG_W+7];
        s_sw_enable = sync2_q[TAG_W+6];
        sym.tag = sync2_q[TAG_W+5:6];
        sym.valid = sync2_q[5];
        sym.retry = sync2_q[4];
        sym.not_accepted = sync2_q[3];
        sym.crc_error = sync2_q[2];
        s_output_error = sync2_q[1];
        // Symbol reports are sampled on rising link clock edges
        link_edge = sync2_q[0] & ~link_clk_prev_q;
        port_enabled = s_training_done & s_sw_enable;
    end

    // Error-free symbol seen at a link clock rising edge
    function automatic logic clean_symbol(input symbol_t s,
                                          input logic edge_seen);
        clean_symbol = edge_seen & s.valid & ~s.crc_error;
    endfunction

    function automatic logic good_retry(input symbol_t s, input logic edge_seen);
        good_retry = clean_symbol(s, edge_seen) & s.retry;
    endfunction

    function automatic logic bad_accept(input symbol_t s,
                                        input logic edge_seen);
        bad_accept = clean_symbol(s, edge_seen) & s.not_accepted;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge-tag scoreboard

    logic [TAG_W-1:0] tag_q;
    logic [TAG_W-1:0] tag_d;
    logic tag_load;

    ////////////////////////////////////////////////////////////////////////
    // Stop procedure counter

    logic [2:0] stop_cnt_q;
    logic [2:0] stop_cnt_d;
    logic stop_clear;
    logic stop_step;
    logic stop_done;

    ////////////////////////////////////////////////////////////////////////
    // Resend pulse and progress flag

    logic resend_start_q;
    logic resend_start_d;
    logic resent_q;
    logic resent_d;
    logic resend_fire;
    logic resend_arm;

    ////////////////////////////////////////////////////////////////////////
    // State machine

    retry_state_t state_q;
    retry_state_t state_d;
    logic [TAG_W-1:0] retry_tag_q;
    logic [TAG_W-1:0] retry_tag_d;
    port_status_t stat_q;
    port_status_t stat_d;
    logic retry_hit;
    logic recover_fault;

    always_comb begin
        state_d = state_q;
        retry_tag_d = retry_tag_q;
        stat_d = stat_q;
        tag_load = 1'b0;
        stop_clear = 1'b0;
        stop_step = 1'b0;
        resend_fire = 1'b0;
        resend_arm = 1'b0;
        retry_hit = good_retry(sym, link_edge);
        recover_fault = bad_accept(sym, link_edge) | s_output_error;
        stat_d.to_error_recovery = 1'b0;
        case (state_q)
            ST_DISABLED: begin
                stat_d.port_ready = 1'b0;
                stat_d.retry_halted = 1'b0;
                stat_d.launch_enable = 1'b0;
                if (port_enabled) begin
                    state_d = ST_WAIT;
                    stat_d.port_ready = 1'b1;
                    stat_d.launch_enable = 1'b1;
                end
            end
            ST_WAIT: begin
                if (!port_enabled) begin
                    state_d = ST_DISABLED;
                    stat_d.port_ready = 1'b0;
                    stat_d.launch_enable = 1'b0;
                end else if (retry_hit) begin
                    state_d = ST_STOP;
                    retry_tag_d = sym.tag;
                    stop_clear = 1'b1;
                    stat_d.port_ready = 1'b0;
                    stat_d.retry_halted = 1'b1;
                    stat_d.launch_enable = 1'b0;
                end
            end
            ST_STOP: begin
                if (!port_enabled) begin
                    state_d = ST_DISABLED;
                    stat_d.retry_halted = 1'b0;
                end else if (stop_done) begin
                    state_d = ST_RECOVER;
                    resend_arm = 1'b1;
                end else begin
                    stop_step = 1'b1;
                end
            end
            ST_RECOVER: begin
                if (!port_enabled) begin
                    state_d = ST_DISABLED;
                    stat_d.retry_halted = 1'b0;
                    stat_d.launch_enable = 1'b0;
                end else if (recover_fault) begin
                    state_d = ST_WAIT;
                    stat_d.to_error_recovery = 1'b1;
                    stat_d.retry_halted = 1'b0;
                    stat_d.launch_enable = 1'b0;
                end else if (!resent_q) begin
                    tag_load = 1'b1;
                    resend_fire = 1'b1;
                    stat_d.retry_halted = 1'b0;
                    stat_d.port_ready = 1'b1;
                    stat_d.launch_enable = 1'b1;
                end else begin
                    state_d = ST_WAIT;
                end
            end
            default: begin
                state_d = ST_DISABLED;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_DISABLED;
            retry_tag_q <= TAG_RESET;
            stat_q <= '0;
        end else begin
            state_q <= state_d;
            retry_tag_q <= retry_tag_d;
            stat_q <= stat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop procedure counter update

    always_comb begin
        stop_cnt_d = stop_cnt_q;
        stop_done = (stop_cnt_q == STOP_CNT_LAST);
        if (stop_clear) begin
            stop_cnt_d = STOP_CNT_RESET;
        end else if (stop_step) begin
            stop_cnt_d = 3'(stop_cnt_q + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stop_cnt_q <= STOP_CNT_RESET;
        end else begin
            stop_cnt_q <= stop_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Resend pulse update

    always_comb begin
        resend_start_d = resend_fire;
        resent_d = resent_q;
        if (resend_arm) begin
            resent_d = 1'b0;
        end else if (resend_fire) begin
            resent_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            resend_start_q <= 1'b0;
            resent_q <= 1'b0;
        end else begin
            resend_start_q <= resend_start_d;
            resent_q <= resent_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scoreboard update

    always_comb begin
        tag_d = tag_q;
        if (tag_load) begin
            tag_d = retry_tag_q;
        end else if (packet_sent && stat_q.launch_enable) begin
            tag_d = TAG_W'(tag_q + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tag_q <= TAG_RESET;
        end else begin
            tag_q <= tag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        port_ready = stat_q.port_ready;
        retry_halted = stat_q.retry_halted;
        launch_enable = stat_q.launch_enable;
        to_error_recovery = stat_q.to_error_recovery;
        resend_start = resend_start_q;
        resend_tag = retry_tag_q;
        next_tag = tag_q;
        state_out = state_q;
    end

endmodule // output_port_retry_recovery

`default_nettype wire

// file: rtl/retry_recovery_pkg.sv
// Package for the output-port retry recovery block
package retry_recovery_pkg;

    localparam int TAG_W = 3;
    localparam int TAG_COUNT = 8;
    localparam logic [TAG_W-1:0] TAG_RESET = 3'h0;
    localparam int STOP_CYCLES = 4;
    localparam logic [2:0] STOP_CNT_RESET = 3'h0;
    localparam logic [2:0] STOP_CNT_LAST = 3'(STOP_CYCLES - 1);

    typedef enum logic [1:0] {
        ST_DISABLED = 2'b00,
        ST_WAIT = 2'b01,
        ST_STOP = 2'b11,
        ST_RECOVER = 2'b10
    } retry_state_t;

    // Control symbol report from the receive side of the link
    typedef struct packed {
        logic valid;
        logic retry;
        logic not_accepted;
        logic crc_error;
        logic [TAG_W-1:0] tag;
    } symbol_t;

    // Status presented by the output port
    typedef struct packed {
        logic port_ready;
        logic retry_halted;
        logic launch_enable;
        logic to_error_recovery;
    } port_status_t;

endpackage

// file: verification/far_input_port.sv
// Model of the far input port sending control symbols
`timescale 1ns/10ps
`default_nettype none
module far_input_port
    import retry_recovery_pkg::*;
(
    output logic link_clk,
    output var symbol_t sym
);
    logic [TAG_W-1:0] exp_tag = TAG_RESET;
    initial begin
        link_clk = 1'b0;
        sym = '0;
    end
    // One symbol per frame; link clock idles low, fields scrambled after
    task automatic send(input logic re, input logic na, input logic crc);
        #8 sym = '{1'b1, re, na, crc, exp_tag};
        #16 link_clk = 1'b1;
        #16 link_clk = 1'b0;
        sym = '{1'b0, ~re, ~na, ~crc, ~exp_tag};
    endtask
endmodule // far_input_port
`default_nettype wire

// file: verification/output_port_retry_recovery_tb.sv
// Testbench for the retry recovery block
`timescale 1ns/10ps
`default_nettype none
module output_port_retry_recovery_tb;
    import retry_recovery_pkg::*;
    logic clk_sys, arst_n, training_done, sw_enable, output_error, packet_sent;
    logic link_clk, port_ready, retry_halted, launch_enable, resend_start;
    logic to_error_recovery;
    logic [TAG_W-1:0] resend_tag, next_tag;
    logic [1:0] state_out;
    symbol_t sym;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    output_port_retry_recovery dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .training_done(training_done), .sw_enable(sw_enable),
        .symbol_tag(sym.tag), .symbol_valid(sym.valid),
        .symbol_retry(sym.retry), .symbol_not_accepted(sym.not_accepted),
        .symbol_crc_error(sym.crc_error), .output_error(output_error),
        .packet_sent(packet_sent), .link_clk(link_clk),
        .port_ready(port_ready), .retry_halted(retry_halted),
        .launch_enable(launch_enable), .resend_start(resend_start),
        .resend_tag(resend_tag), .to_error_recovery(to_error_recovery),
        .next_tag(next_tag), .state_out(state_out));
    far_input_port peer (.link_clk(link_clk), .sym(sym));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic wait_st(input logic [1:0] s, input int n);
        for (int i = 0; i < n && state_out !== s; i++) @(negedge clk_sys);
    endtask
    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(negedge clk_sys);
    endtask
    task automatic retry_to_stop(input logic [TAG_W-1:0] t);
        peer.exp_tag = t;
        peer.send(1'b1, 1'b0, 1'b0);
        wait_st(ST_STOP, 8);
        chk(state_out === ST_STOP && retry_halted === 1'b1, "no stop");
    endtask
    task automatic t_enable();
        chk(state_out === ST_DISABLED, "reset state");
        sw_enable = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk(state_out === ST_DISABLED, "enabled untrained");
        training_done = 1'b1;
        wait_st(ST_WAIT, 8);
        chk(state_out === ST_WAIT, "no wait");
        peer.send(1'b1, 1'b0, 1'b1);
        peer.send(1'b0, 1'b1, 1'b0);
        repeat (8) @(negedge clk_sys);
        chk(state_out === ST_WAIT && retry_halted === 1'b0, "bad symbol");
        $display("test enable done");
    endtask
    task automatic t_retry();
        repeat (3) begin
            packet_sent = 1'b1;
            @(negedge clk_sys);
            packet_sent = 1'b0;
            @(negedge clk_sys);
        end
        chk(next_tag === 3'h3, "tag count");
        retry_to_stop(3'h1);
        chk(port_ready === 1'b0 && launch_enable === 1'b0, "stop flags");
        wait_hi(resend_start, 10);
        chk(resend_tag === 3'h1 && next_tag === 3'h1, "resend");
        @(negedge clk_sys);
        chk(state_out === ST_WAIT, "no return");
        $display("test retry done");
    endtask
    task automatic t_fault();
        retry_to_stop(3'h6);
        output_error = 1'b1;
        wait_hi(to_error_recovery, 10);
        chk(to_error_recovery === 1'b1 && resend_start === 1'b0, "handover");
        output_error = 1'b0;
        @(negedge clk_sys);
        chk(state_out === ST_WAIT && retry_halted === 1'b0, "after fault");
        retry_to_stop(3'h2);
        sw_enable = 1'b0;
        wait_st(ST_DISABLED, 8);
        chk(state_out === ST_DISABLED && retry_halted === 1'b0, "abandon");
        sw_enable = 1'b1;
        wait_st(ST_WAIT, 8);
        training_done = 1'b0;
        wait_st(ST_DISABLED, 8);
        chk(state_out === ST_DISABLED, "wait disable");
        $display("test fault done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        arst_n = 1'b0;
        training_done = 1'b0;
        sw_enable = 1'b0;
        output_error = 1'b0;
        packet_sent = 1'b0;
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_enable();
        t_retry();
        t_fault();
        give_verdict();
    end
endmodule // output_port_retry_recovery_tb
`default_nettype wire

// file: verification/retry_recovery_properties.sv
// Checker for the retry recovery block
`timescale 1ns/10ps
`default_nettype none
module retry_recovery_properties
    import retry_recovery_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic training_done,
    input wire logic sw_enable,
    input wire logic port_ready,
    input wire logic retry_halted,
    input wire logic launch_enable,
    input wire logic resend_start,
    input wire logic [TAG_W-1:0] resend_tag,
    input wire logic to_error_recovery,
    input wire logic [TAG_W-1:0] next_tag,
    input wire logic [1:0] state_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence stop_run;
        (state_out == ST_STOP)[*4];
    endsequence
    sequence back_to_wait;
        ##1 state_out inside {ST_WAIT, ST_DISABLED};
    endsequence
    stop_flags_a: assert property (state_out == ST_STOP |->
        !port_ready && retry_halted && !launch_enable) else $error("stop flags");
    stop_length_a: assert property (disable iff (!arst_n || !sw_enable)
        $rose(state_out == ST_STOP) |-> stop_run ##1 state_out == ST_RECOVER)
        else $error("stop length");
    recover_entry_a: assert property ($rose(state_out == ST_RECOVER) |->
        $past(state_out, 4) == ST_STOP) else $error("recover entry");
    resend_point_a: assert property (resend_start |-> next_tag == resend_tag
        && port_ready && !retry_halted && state_out == ST_RECOVER)
        else $error("resend point");
    resend_exit_a: assert property (resend_start |-> back_to_wait)
        else $error("recover exit");
    fault_handover_a: assert property (to_error_recovery |->
        $past(state_out) == ST_RECOVER && !resend_start && !retry_halted)
        else $error("fault handover");
    disabled_gate_a: assert property ((!(training_done && sw_enable))[*4]
        |-> state_out == ST_DISABLED) else $error("not disabled");
    disabled_quiet_a: assert property (state_out == ST_DISABLED |->
        !retry_halted && !resend_start) else $error("halted while disabled");
endmodule // retry_recovery_properties
bind output_port_retry_recovery retry_recovery_properties props (.*);
`default_nettype wire
